/* File: hdl/conv_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module conv_timer #(
  parameter int SHORT_CYCLES = light_ctrl_pkg::SHORT_CYCLES,
  parameter int LONG_CYCLES = light_ctrl_pkg::LONG_CYCLES,
  parameter int CNT_W = light_ctrl_pkg::CNT_W
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic start, // (re)load and run
  input wire logic abort, // stop without done
  input wire logic long_sel, // 1 selects the long period
  output logic done // one-cycle end pulse
);
  if (SHORT_CYCLES < 1 || LONG_CYCLES < 1 || LONG_CYCLES >= (2 ** CNT_W) || SHORT_CYCLES >= (2 ** CNT_W)) begin : g_chk
    $error("conv_timer: period does not fit the counter");
  end

  logic [CNT_W-1:0] cnt_r;
  logic run_r;
  wire [CNT_W-1:0] load_val = long_sel ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1); // R7
  wire expire = run_r && (cnt_r == '0);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= expire && !start && !abort;
      if (start) begin
        cnt_r <= load_val;
        run_r <= 1'b1;
      end else if (abort || expire) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/light_conv_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module light_conv_ctrl #(
  parameter int SHORT_CYCLES = light_ctrl_pkg::SHORT_CYCLES,
  parameter int LONG_CYCLES = light_ctrl_pkg::LONG_CYCLES
) (
  input wire logic clock, // 50 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] reg_addr, // register address from the serial slave
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata_r, // read data, valid the cycle after reg_rd
  input wire logic [11:0] adc_mantissa, // converter count at conversion end
  input wire logic adc_overflow, // converter overload during conversion
  input wire logic high_limit_flag, // high limit flag from the limit logic
  input wire logic low_limit_hit, // low limit flag from the limit logic
  output logic conv_active_r, // a conversion is running
  output logic [3:0] conv_range_r, // range applied to the converter
  output logic conv_long_r, // 1 = long conversion period in use
  output logic [3:0] alert_cfg_r, // latch, polarity, fault count bits for the alert logic
  output logic [15:0] result_r // result register contents
);
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;

  conv_state_t state_r;
  logic [3:0] range_select_r;
  logic conversion_period_sel_r;
  logic [1:0] mode_r;
  logic overflow_flag_r;
  logic ready_flag_r;
  logic [4:0] low_cfg_r;
  logic over_seen_r;
  logic raised_r;
  logic timer_done;

  if (SHORT_CYCLES < 1 || LONG_CYCLES < 1) begin : g_period_chk
    $error("light_conv_ctrl: conversion periods must be at least one cycle");
  end

  // short conversions at ranges 0000b to 0101b keep fewer significant low bits
  function automatic logic [11:0] res_mask(input logic [3:0] rng, input logic long_t);
    logic [11:0] m;
    m = 12'hFFF;
    if (!long_t) begin
      if (rng == 4'h5) m = 12'hFFE;
      else if (rng >= 4'h1 && rng <= 4'h4) m = 12'hFFC;
      else if (rng == 4'h0) m = 12'hFF8;
    end
    return m;
  endfunction

  wire cfg_hit = reg_addr == light_ctrl_pkg::ADDR_CFG; // R13
  wire res_hit = reg_addr == light_ctrl_pkg::ADDR_RESULT;
  wire cfg_wr = reg_wr && cfg_hit;
  wire cfg_rd = reg_rd && cfg_hit;
  wire [3:0] wr_range = reg_wdata[light_ctrl_pkg::RANGE_MSB:light_ctrl_pkg::RANGE_LSB];
  wire [1:0] wr_mode = reg_wdata[light_ctrl_pkg::MODE_MSB:light_ctrl_pkg::MODE_LSB];
  wire wr_long = reg_wdata[light_ctrl_pkg::PERIOD_BIT];
  wire wr_go = wr_mode != light_ctrl_pkg::MODE_OFF; // R10
  wire auto_rng = range_select_r == light_ctrl_pkg::RANGE_AUTO; // R5
  wire mask_exp = low_cfg_r[light_ctrl_pkg::EXP_MASK_BIT] && (range_select_r < light_ctrl_pkg::RANGE_AUTO);
  wire in_conv = state_r == ST_CONV;
  // reserved range codes are not guarded; the host keeps them out
  // overload in the completion cycle only feeds the flag, else a single shot would restart after shutdown
  wire step_up = in_conv && !timer_done && adc_overflow && auto_rng && (conv_range_r < light_ctrl_pkg::RANGE_MAX); // R16
  wire finish = timer_done && !cfg_wr;
  wire continuous = mode_r[1];
  wire [3:0] start_range = (wr_range == light_ctrl_pkg::RANGE_AUTO) ? light_ctrl_pkg::RANGE_MIN : wr_range;
  wire timer_start = (cfg_wr && wr_go) || (!cfg_wr && step_up) || (finish && continuous); // R3 R16 R17
  wire timer_long = cfg_wr ? wr_long : conversion_period_sel_r;
  wire [3:0] res_exp = mask_exp ? 4'h0 : conv_range_r; // R1 R5
  wire [11:0] res_man = adc_mantissa & res_mask(conv_range_r, conv_long_r); // R8 R9
  wire [15:0] cfg_word = {range_select_r, conversion_period_sel_r, mode_r, overflow_flag_r, ready_flag_r,
                          high_limit_flag, low_limit_hit, low_cfg_r}; // R12
  wire [15:0] rd_mux = cfg_hit ? cfg_word : (res_hit ? result_r : 16'h0000);
  wire ready_clear = cfg_rd || (cfg_wr && wr_go); // R15

  conv_timer #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .CNT_W(light_ctrl_pkg::CNT_W)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .start(timer_start),
    .abort(cfg_wr), // R2
    .long_sel(timer_long),
    .done(timer_done)
  );

  // configuration fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      range_select_r <= light_ctrl_pkg::CFG_RESET[light_ctrl_pkg::RANGE_MSB:light_ctrl_pkg::RANGE_LSB]; // R4
      conversion_period_sel_r <= light_ctrl_pkg::CFG_RESET[light_ctrl_pkg::PERIOD_BIT]; // R7
      mode_r <= light_ctrl_pkg::CFG_RESET[light_ctrl_pkg::MODE_MSB:light_ctrl_pkg::MODE_LSB]; // R10
      low_cfg_r <= light_ctrl_pkg::CFG_RESET[light_ctrl_pkg::LOW_MSB:0]; // R13
      alert_cfg_r <= {light_ctrl_pkg::CFG_RESET[4:3], light_ctrl_pkg::CFG_RESET[1:0]};
    end else if (ce) begin
      if (cfg_wr) begin
        range_select_r <= wr_range;
        conversion_period_sel_r <= wr_long;
        mode_r <= wr_mode;
        low_cfg_r <= reg_wdata[light_ctrl_pkg::LOW_MSB:0];
        alert_cfg_r <= {reg_wdata[4:3], reg_wdata[1:0]};
      end else if (finish && mode_r == light_ctrl_pkg::MODE_SINGLE) begin
        mode_r <= light_ctrl_pkg::MODE_OFF; // R11
      end
    end
  end

  // conversion sequencing; a write in the completion cycle wins and drops that result
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      conv_active_r <= 1'b0;
      conv_range_r <= light_ctrl_pkg::RANGE_MIN;
      conv_long_r <= light_ctrl_pkg::CFG_RESET[light_ctrl_pkg::PERIOD_BIT];
      over_seen_r <= 1'b0;
      raised_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (cfg_wr && wr_go) begin
            state_r <= ST_CONV; // R3
            conv_active_r <= 1'b1;
          end
        end
        ST_CONV: begin
          if (cfg_wr && !wr_go) begin
            state_r <= ST_IDLE; // R2
            conv_active_r <= 1'b0;
          end else if (finish && !continuous) begin
            state_r <= ST_IDLE; // R11
            conv_active_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          conv_active_r <= 1'b0;
        end
      endcase
      if (cfg_wr) begin
        conv_range_r <= start_range;
        conv_long_r <= wr_long;
        over_seen_r <= 1'b0;
        raised_r <= 1'b0;
      end else if (step_up) begin
        conv_range_r <= conv_range_r + 4'h1; // R16
        raised_r <= 1'b1;
        over_seen_r <= 1'b0;
      end else if (finish) begin
        over_seen_r <= 1'b0;
        raised_r <= 1'b0;
      end else if (in_conv && adc_overflow) begin
        over_seen_r <= 1'b1;
      end
    end
  end

  // result, flags and read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result_r <= light_ctrl_pkg::RESULT_RESET;
      overflow_flag_r <= 1'b0;
      ready_flag_r <= 1'b0;
      reg_rdata_r <= 16'h0000;
    end else if (ce) begin
      if (finish) begin
        result_r <= {res_exp, res_man}; // R14
        overflow_flag_r <= over_seen_r || raised_r || adc_overflow; // R16
      end
      // a completion in the clearing cycle still sets the flag
      if (finish) ready_flag_r <= 1'b1; // R15
      else if (ready_clear) ready_flag_r <= 1'b0;
      if (reg_rd) reg_rdata_r <= rd_mux;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  mask_exponent_a: assert property (ce && finish && mask_exp |=> result_r[15:12] == 4'h0) // R1
    else $error("masked exponent not zero");
  write_abort_a: assert property (ce && cfg_wr && !wr_go |=> !conv_active_r ##1 !timer_done) // R2
    else $error("write did not abort conversion");
  write_start_a: assert property (ce && cfg_wr && wr_go |=> conv_active_r && conv_range_r == $past(start_range)) // R3
    else $error("write did not start conversion");
  auto_exp_a: assert property (ce && finish && auto_rng |=> result_r[15:12] == $past(conv_range_r)) // R5
    else $error("auto range not reported");
  short_res_a: assert property (ce && finish && !conv_long_r && conv_range_r == 4'h0 |=> result_r[2:0] == 3'h0) // R8
    else $error("resolution drop missing");
  single_end_a: assert property (ce && finish && mode_r == 2'h1 |=> mode_r == 2'h0 && !conv_active_r) // R11
    else $error("single-shot did not shut down");
  ready_set_a: assert property (ce && finish |=> ready_flag_r) // R15
    else $error("ready flag not set");
  ready_clear_a: assert property (ce && cfg_rd && !finish |=> !ready_flag_r) // R15
    else $error("ready flag not cleared by read");
  range_step_a: assert property (ce && step_up && !cfg_wr |=> conv_range_r == $past(conv_range_r) + 4'h1) // R16
    else $error("auto range did not step");
  continuous_a: assert property (ce && finish && continuous |=> conv_active_r ##1 (in_conv || $past(cfg_wr))) // R17
    else $error("continuous mode stopped");
  period_sel_a: assert property (ce && cfg_wr |=> conv_long_r == $past(wr_long)) // R7
    else $error("conversion period not taken from write");
  mode_hold_a: assert property (ce && finish && continuous |=> mode_r == $past(mode_r)) // R10
    else $error("continuous mode field changed");
  result_update_a: assert property (ce && finish && conv_long_r |=> result_r[11:0] == $past(adc_mantissa)) // R14
    else $error("result mantissa not updated");
  write_clear_a: assert property (ce && cfg_wr && wr_go |=> !ready_flag_r) // R15
    else $error("ready flag not cleared by write");

  single_shot_c: cover property (ce && finish && mode_r == 2'h1);
  range_step_c: cover property (ce && step_up);
  abort_c: cover property (ce && cfg_wr && in_conv);
  continuous_c: cover property (ce && finish && continuous);
  mask_c: cover property (ce && finish && mask_exp);
endmodule
`default_nettype wire

/* File: hdl/light_ctrl_pkg.sv */
// Contract
// R1 - Exponent mask set with manual range below 1100b reports exponent zero.
// R2 - Any configuration write aborts a running conversion at once.
// R3 - After a configuration write requesting conversion, start a fresh one with new settings.
// R4 - Range select in bits 15:12 uses exponent encoding, resets to 1100b.
// R5 - Range 1100b selects automatic ranging; chosen range goes to result exponent.
// R6 - Host must not program reserved range codes 1101b, 1110b, 1111b.
// R7 - Conversion-time bit: zero gives 100 ms, one gives 800 ms; resets to one.
// R8 - Short time drops resolution: one bit range 0101b, two 0100b-0001b, three 0000b.
// R9 - Result layout and LSB weight do not depend on conversion time.
// R10 - Mode bits 10:9: 00 shutdown, 01 single-shot, 1x continuous; reset 00.
// R11 - Single-shot reads 01b while converting, then field becomes 00b, shutdown.
// R12 - Bits 8 to 5 are read-only flags; all other bits read and write.
// R13 - Configuration register at address 01h, reset value C810h.
// R14 - Result holds 4-bit exponent over 12-bit mantissa, updated every completed conversion.
// R15 - Ready flag sets at conversion end; clears on config read or non-shutdown write.
// R16 - Auto mode overflow below maximum aborts, raises range, restarts, sets overflow flag.
// R17 - Continuous mode starts the next conversion right after each completes.
package light_ctrl_pkg;
  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h01;
  localparam logic [15:0] CFG_RESET = 16'hC810;
  localparam int RANGE_MSB = 15;
  localparam int RANGE_LSB = 12;
  localparam int PERIOD_BIT = 11;
  localparam int MODE_MSB = 10;
  localparam int MODE_LSB = 9;
  localparam int OVERFLOW_BIT = 8;
  localparam int RDY_BIT = 7;
  localparam int LOW_MSB = 4;
  localparam int EXP_MASK_BIT = 2;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 12;
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;
  localparam logic [3:0] RANGE_MIN = 4'h0;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CLK_KHZ = 50000;
  localparam int SHORT_MS = 100;
  localparam int LONG_MS = 800;
  localparam int SHORT_CYCLES = SHORT_MS * CLK_KHZ;
  localparam int LONG_CYCLES = LONG_MS * CLK_KHZ;
  localparam int CNT_W = 26;
endpackage

/* File: tb/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clock, // system clock
  output logic [7:0] reg_addr, // register address
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata_r // read data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = 16'h0000;
  end
  // callers never hand codes Dh..Fh in the range field
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    reg_wdata <= ~d; // released data must not look valid
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata_r;
  endtask
endmodule
`default_nettype wire

/* File: tb/light_sensor_conversion_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module light_sensor_conversion_control_bench;
  localparam int SH = 20;
  localparam int LG = 160;
  typedef struct packed {
    logic [15:0] cfg;
    logic [11:0] mant;
    logic [15:0] res;
  } row_t;
  logic clock, rst_n, ce, reg_wr, reg_rd, adc_overflow, high_limit_flag, low_limit_hit;
  logic conv_active_r, conv_long_r;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_r, result_r, d;
  logic [11:0] adc_mantissa;
  logic [3:0] conv_range_r, alert_cfg_r;
  int checks = 0;
  int n_mismatch = 0;
  row_t rows [8] = '{
    '{16'h3A14, 12'hABC, 16'h0ABC},
    '{16'h3A10, 12'hABC, 16'h3ABC},
    '{16'h5210, 12'hABD, 16'h5ABC},
    '{16'h2210, 12'hABF, 16'h2ABC},
    '{16'h0210, 12'hABF, 16'h0AB8},
    '{16'h6210, 12'hABF, 16'h6ABF},
    '{16'hBA10, 12'hFFF, 16'hBFFF},
    '{16'hCA10, 12'h123, 16'h0123}
  };
  host_model u_host_model (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));
  light_conv_ctrl #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG)) u_light_conv_ctrl (.clock(clock),
    .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .adc_mantissa(adc_mantissa),
    .adc_overflow(adc_overflow), .high_limit_flag(high_limit_flag), .low_limit_hit(low_limit_hit),
    .conv_active_r(conv_active_r), .conv_range_r(conv_range_r), .conv_long_r(conv_long_r),
    .alert_cfg_r(alert_cfg_r), .result_r(result_r));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // bounded wait, so a conversion that never ends cannot hang the run
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (conv_active_r !== 1'h0 && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("idle", {15'h0, conv_active_r}, 16'h0000);
  endtask
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    adc_overflow = 1'h0;
    high_limit_flag = 1'h0;
    low_limit_hit = 1'h0;
    adc_mantissa = 12'h000;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      adc_mantissa <= rows[i].mant;
      u_host_model.wr(8'h01, rows[i].cfg);
      chk("long", {15'h0, conv_long_r}, {15'h0, rows[i].cfg[11]});
      chk("range", {12'h0, conv_range_r},
        {12'h0, (rows[i].cfg[15:12] == 4'hC) ? 4'h0 : rows[i].cfg[15:12]});
      u_host_model.rd(8'h01, d);
      chk("mode", {14'h0, d[10:9]}, 16'h0001);
      wait_idle(LG + 8);
      u_host_model.rd(8'h00, d);
      chk("result", d, rows[i].res);
      chk("result_reg", result_r, rows[i].res);
      u_host_model.rd(8'h01, d);
      chk("cfg", d, {rows[i].cfg[15:11], 4'h1, 2'h0, rows[i].cfg[4:0]});
    end
    $display("test rows done");
    u_host_model.wr(8'h01, 16'h3A10);
    repeat (20) @(posedge clock);
    u_host_model.wr(8'h01, 16'h5210);
    chk("range", {12'h0, conv_range_r}, 16'h0005);
    wait_idle(SH + 4);
    u_host_model.rd(8'h00, d);
    chk("result", d, 16'h5122);
    $display("test abort done");
    u_host_model.wr(8'h01, 16'h3410);
    repeat (3 * SH + 10) @(posedge clock);
    #1;
    chk("active", {15'h0, conv_active_r}, 16'h0001);
    u_host_model.rd(8'h01, d);
    chk("cfg", d, 16'h3490);
    u_host_model.rd(8'h00, d);
    chk("result", d, 16'h3120);
    $display("test continuous done");
    @(posedge clock);
    adc_overflow <= 1'h1;
    u_host_model.wr(8'h01, 16'hC210);
    repeat (16) @(posedge clock);
    adc_overflow <= 1'h0;
    #1;
    chk("range", {12'h0, conv_range_r}, 16'h000B);
    wait_idle(SH + 10);
    u_host_model.rd(8'h00, d);
    chk("result", d, 16'hB123);
    u_host_model.rd(8'h01, d);
    chk("cfg", d, 16'hC190);
    $display("test autorange done");
    @(posedge clock);
    rst_n <= 1'h0;
    high_limit_flag <= 1'h1;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    u_host_model.rd(8'h01, d);
    chk("cfg", d, 16'hC850);
    u_host_model.wr(8'h00, 16'hFFFF);
    u_host_model.rd(8'h00, d);
    chk("result", d, 16'h0000);
    u_host_model.rd(8'h05, d);
    chk("unmapped", d, 16'h0000);
    u_host_model.wr(8'h01, 16'h01F9);
    u_host_model.rd(8'h01, d);
    chk("cfg", d, 16'h0059);
    chk("alert", {12'h0, alert_cfg_r}, 16'h000D);
    $display("test reset done");
    // with the enable low the timer must not advance, so the conversion outlives its period
    u_host_model.wr(8'h01, 16'h5210);
    @(posedge clock);
    ce <= 1'h0;
    repeat (2 * SH) @(posedge clock);
    #1;
    chk("frozen", {15'h0, conv_active_r}, 16'h0001);
    @(posedge clock);
    ce <= 1'h1;
    wait_idle(SH + 4);
    u_host_model.rd(8'h00, d);
    chk("result", d, 16'h5122);
    $display("test freeze done");
    final_report();
  end
endmodule
`default_nettype wire
